//--- rtl/sth_task_handler.v
// Scaler task handler: chooses task A or B, waits for trigger, counts skips.
// Assumes pins from the decoder or port are asynchronous; config is static.
`timescale 1ns/10ps
`include "sth_defs.vh"
module sth_task_handler (
    input wire i_clk_sys,
    input wire i_srst,
    input wire i_scaler_soft_reset_n,
    input wire i_task_a_enable,
    input wire i_task_b_enable,
    input wire [7:0] i_cfg_a,
    input wire [7:0] i_cfg_b,
    input wire i_ext_source,
    input wire i_sys_60hz,
    input wire i_vtrig_sel_hi,
    input wire i_vtrig_edge_sel,
    input wire i_htrig_edge_sel,
    input wire i_decoder_vertical_pulse,
    input wire i_decoder_line_reference,
    input wire i_ext_vsync,
    input wire i_ext_sav,
    input wire i_field_identifier,
    input wire i_offsets_reached,
    input wire i_task_done,
    output reg o_task_active,
    output reg o_task_b_sel,
    output reg o_toggle,
    output reg o_sav_d6,
    output reg o_sav_d7,
    output reg o_task_flag,
    output reg o_field_id_out,
    output reg o_idle
);
    localparam ST_IDLE = 2'h0;
    localparam ST_WAIT = 2'h1;
    localparam ST_RUN = 2'h2;
    localparam ST_ARM = 2'h3;

    wire vp_lvl;
    wire vp_rise;
    wire vp_fall;
    wire hr_rise;
    wire hr_lvl;
    wire ev_fall;
    wire sav_rise;
    wire ev_lvl;
    wire sav_lvl;
    reg fid_m_q;
    reg fid_q;
    reg swr_m_q;
    reg swr_q;

    sth_edge u_vp (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
        .i_async(i_decoder_vertical_pulse), .o_level(vp_lvl),
        .o_rise(vp_rise), .o_fall(vp_fall));
    sth_edge u_hr (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
        .i_async(i_decoder_line_reference), .o_level(hr_lvl),
        .o_rise(hr_rise), .o_fall());
    sth_edge u_ev (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
        .i_async(i_ext_vsync), .o_level(ev_lvl),
        .o_rise(), .o_fall(ev_fall));
    sth_edge u_sv (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
        .i_async(i_ext_sav), .o_level(sav_lvl),
        .o_rise(sav_rise), .o_fall());

    // Soft reset and field ID come from register and pin domains
    always @(posedge i_clk_sys) begin
        if (i_srst) begin
            fid_m_q <= 1'b0;
            fid_q <= 1'b0;
            swr_m_q <= 1'b1;
            swr_q <= 1'b1;
        end else begin
            fid_m_q <= i_field_identifier;
            fid_q <= fid_m_q;
            swr_m_q <= i_scaler_soft_reset_n;
            swr_q <= swr_m_q;
        end
    end

    wire [2:0] trig_sel = {i_vtrig_sel_hi, i_vtrig_edge_sel, i_htrig_edge_sel};
    wire dec_late = (trig_sel == `STH_TRIG_DEC_LATE);
    // Vertical sync event; other select codes fall back to the same edge
    wire vsync_ev = i_ext_source ? ev_fall : vp_fall;
    wire line_ev = i_ext_source ? sav_rise : hr_rise;

    reg [11:0] line_q;
    reg [11:0] start_line;
    always @* begin
        start_line = `STH_LINE_DEC_E_50;
        if (i_ext_source) begin
            start_line = i_sys_60hz ? `STH_LINE_EXT_60 : `STH_LINE_EXT_50;
        end else if (dec_late) begin
            if (!fid_q) begin
                start_line = i_sys_60hz ? `STH_LINE_DEC_F1_60 :
                    `STH_LINE_DEC_F1_50;
            end else begin
                start_line = i_sys_60hz ? `STH_LINE_DEC_F2_60 :
                    `STH_LINE_DEC_F2_50;
            end
        end else begin
            start_line = i_sys_60hz ? `STH_LINE_DEC_E_60 :
                `STH_LINE_DEC_E_50;
        end
    end
    wire line_ok = (line_q >= start_line);

    reg [1:0] state_q;
    reg cur_b_q;
    reg first_q;
    reg rpt_done_q;
    reg [2:0] skip_q;
    reg vs_seen_q;
    reg ph_ok_q;

    // Config of the selected task; read live in every state, except the skip count, which ST_ARM latches into skip_q
    wire [7:0] cfg = cur_b_q ? i_cfg_b : i_cfg_a;
    wire [1:0] start_condition_sel = cfg[`STH_CFG_START_CONDITION_SEL_MSB:`STH_CFG_START_CONDITION_SEL_LSB];
    wire [2:0] field_skip_count = cfg[`STH_CFG_SKIP_MSB:`STH_CFG_SKIP_LSB];

    reg cond_ok;
    always @* begin
        cond_ok = 1'b0;
        case (start_condition_sel)
            `STH_START_CONDITION_SEL_IMM: cond_ok = 1'b1;
            `STH_START_CONDITION_SEL_VSYNC: cond_ok = vs_seen_q;
            `STH_START_CONDITION_SEL_FID0: cond_ok = ~fid_q;
            default: cond_ok = fid_q;
        endcase
    end

    // Next task after completion; enables are also sampled in ST_IDLE
    reg nxt_b;
    reg nxt_any;
    always @* begin
        nxt_b = cur_b_q;
        nxt_any = i_task_a_enable | i_task_b_enable;
        if (i_task_a_enable && i_task_b_enable) begin
            nxt_b = ~cur_b_q;
        end else if (i_task_b_enable) begin
            nxt_b = 1'b1;
        end else begin
            nxt_b = 1'b0;
        end
    end

    always @(posedge i_clk_sys) begin
        if (i_srst || !swr_q) begin
            state_q <= ST_IDLE;
            cur_b_q <= 1'b1;
            first_q <= 1'b1;
            rpt_done_q <= 1'b0;
            skip_q <= 3'h0;
            vs_seen_q <= 1'b0;
            ph_ok_q <= 1'b0;
            line_q <= 12'h000;
            o_toggle <= 1'b0;
            o_task_active <= 1'b0;
        end else begin
            if (vsync_ev) begin
                line_q <= 12'h000;
            end else if (line_ev && line_q != 12'hfff) begin
                line_q <= line_q + 12'h001;
            end
            case (state_q)
                ST_IDLE: begin
                    // Task B wins the first activation when enabled
                    // Never leave a disabled task selected when rearming
                    if (first_q || !i_task_a_enable) begin
                        cur_b_q <= i_task_b_enable;
                    end
                    if (i_task_a_enable || i_task_b_enable) begin
                        first_q <= 1'b0;
                        state_q <= ST_ARM;
                        vs_seen_q <= 1'b0;
                        skip_q <= 3'h0;
                    end
                end
                ST_ARM: begin
                    // Position already past offsets: wait for next field
                    ph_ok_q <= ~i_offsets_reached;
                    skip_q <= field_skip_count;
                    state_q <= ST_WAIT;
                end
                ST_WAIT: begin
                    if (vsync_ev) begin
                        vs_seen_q <= 1'b1;
                        ph_ok_q <= 1'b1;
                        // Only a field that could have run counts as skipped
                        if (skip_q != 3'h0 && ph_ok_q) begin
                            skip_q <= skip_q - 3'h1;
                        end
                    end else if (ph_ok_q && skip_q == 3'h0 && line_ok &&
                        i_offsets_reached && cond_ok) begin
                        state_q <= ST_RUN;
                        o_task_active <= 1'b1;
                        // Free running, not tied to field detection
                        o_toggle <= ~o_toggle;
                    end
                end
                default: begin
                    if (i_task_done) begin
                        o_task_active <= 1'b0;
                        if (cfg[`STH_CFG_RPT] && !rpt_done_q) begin
                            rpt_done_q <= 1'b1;
                            state_q <= ST_ARM;
                            vs_seen_q <= 1'b0;
                        end else begin
                            rpt_done_q <= 1'b0;
                            cur_b_q <= nxt_b;
                            vs_seen_q <= 1'b0;
                            state_q <= nxt_any ? ST_ARM : ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    always @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_task_b_sel <= 1'b0;
            o_sav_d6 <= 1'b0;
            o_sav_d7 <= 1'b1;
            o_task_flag <= 1'b0;
            o_field_id_out <= 1'b0;
            o_idle <= 1'b1;
        end else begin
            o_task_b_sel <= cur_b_q;
            o_sav_d6 <= cfg[`STH_CFG_OFID] ? o_toggle : fid_q;
            o_field_id_out <= cfg[`STH_CFG_OFID] ? o_toggle : fid_q;
            o_sav_d7 <= ~cfg[`STH_CFG_D7INV];
            o_task_flag <= cfg[`STH_CFG_D7INV];
            o_idle <= (state_q == ST_IDLE);
        end
    end
endmodule

//--- rtl/sth_defs.vh
// Constants for the scaler task handler: field positions and trigger codes.
// Assumes inclusion by the task handler sources only.
`ifndef STH_DEFS_VH
`define STH_DEFS_VH
`define STH_START_CONDITION_SEL_IMM 2'h0
`define STH_START_CONDITION_SEL_VSYNC 2'h1
`define STH_START_CONDITION_SEL_FID0 2'h2
`define STH_START_CONDITION_SEL_FID1 2'h3
`define STH_CFG_START_CONDITION_SEL_LSB 0
`define STH_CFG_START_CONDITION_SEL_MSB 1
`define STH_CFG_RPT 2
`define STH_CFG_SKIP_LSB 3
`define STH_CFG_SKIP_MSB 5
`define STH_CFG_OFID 6
`define STH_CFG_D7INV 7
`define STH_TRIG_DEC_LATE 3'h2
`define STH_TRIG_DEFAULT 3'h0
`define STH_LINE_DEC_F1_50 12'h0004
`define STH_LINE_DEC_F1_60 12'h0007
`define STH_LINE_DEC_F2_50 12'h0003
`define STH_LINE_DEC_F2_60 12'h0006
`define STH_LINE_DEC_E_50 12'h0002
`define STH_LINE_DEC_E_60 12'h0005
`define STH_LINE_EXT_50 12'h0017
`define STH_LINE_EXT_60 12'h0014
`define STH_CFG_RESET 8'h00
`endif

//--- rtl/sth_edge.v
// Two-flop synchroniser with rise and fall pulses on the synchronised level.
// Assumes an asynchronous input and the system clock.
`timescale 1ns/10ps
module sth_edge (
    input wire i_clk_sys,
    input wire i_srst,
    input wire i_async,
    output reg o_level,
    output wire o_rise,
    output wire o_fall
);
    reg meta_q;
    reg lvl_q;
    always @(posedge i_clk_sys) begin
        if (i_srst) begin
            meta_q <= 1'b0;
            lvl_q <= 1'b0;
            o_level <= 1'b0;
        end else begin
            meta_q <= i_async;
            lvl_q <= meta_q;
            o_level <= lvl_q;
        end
    end
    assign o_rise = lvl_q & ~o_level;
    assign o_fall = ~lvl_q & o_level;
endmodule

//--- verification/sth_task_handler_chk.sv
// Checker for the scaler task handler, bound to its top module.
// Assumes one clock domain and the synchronous reset i_srst.
`timescale 1ns/10ps
module sth_task_handler_chk (
    input wire i_clk_sys,
    input wire i_srst,
    input wire i_scaler_soft_reset_n,
    input wire i_task_done,
    input wire o_task_active,
    input wire o_task_b_sel,
    input wire o_toggle,
    input wire o_sav_d6,
    input wire o_sav_d7,
    input wire o_task_flag,
    input wire o_field_id_out,
    input wire o_idle
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_srst);
    a_srst_idle: assert property (disable iff (1'b0) i_srst |=>
        o_idle && o_sav_d7 && !o_task_active && !o_toggle)
        else $error("reset state wrong");
    a_soft_idle: assert property (!i_scaler_soft_reset_n [*5] |->
        o_idle && !o_task_active) else $error("soft reset not idle");
    a_soft_b_first: assert property (!i_scaler_soft_reset_n [*5] |->
        o_task_b_sel && !o_toggle) else $error("task b not first");
    a_toggle_flip: assert property ($rose(o_task_active) |->
        o_toggle != $past(o_toggle)) else $error("toggle kept");
    // Soft reset may cut a task short, so it masks this one
    a_active_holds: assert property (disable iff
        (i_srst || !i_scaler_soft_reset_n) o_task_active && !i_task_done
        |=> o_task_active) else $error("task dropped early");
    a_done_ends: assert property (o_task_active && i_task_done
        |=> !o_task_active) else $error("task outlived done");
    a_d6_pin: assert property (o_sav_d6 == o_field_id_out)
        else $error("d6 and pin differ");
    a_d7_flag: assert property (o_sav_d7 != o_task_flag)
        else $error("d7 not inverse of flag");
    cover property ($rose(o_task_active) && o_task_b_sel);
    cover property ($rose(o_task_active) && !o_task_b_sel);
    cover property (!i_scaler_soft_reset_n && o_task_active);
endmodule

//--- verification/sth_src_model.sv
// Source model: field timing, field id, offsets and task completion.
// Assumes the handler clock; a field is 16 lines of 8 cycles.
`timescale 1ns/10ps
module sth_src_model (
    input wire i_clk_sys,
    input wire i_srst,
    input wire i_active,
    output wire o_vpulse,
    output wire o_decoder_line_reference,
    output wire o_fid,
    output wire o_offs,
    output reg o_done,
    output reg [7:0] o_field
);
    reg [6:0] cyc_q;
    reg [3:0] run_q;
    assign o_vpulse = cyc_q[6:4] == 3'h0;
    assign o_decoder_line_reference = cyc_q[2];
    assign o_fid = o_field[0];
    assign o_offs = cyc_q[6:3] >= 4'ha;
    always @(posedge i_clk_sys) begin
        cyc_q <= i_srst ? 7'h00 : cyc_q + 7'h01;
        if (i_srst)
            o_field <= 8'h00;
        else if (cyc_q == 7'h7f)
            o_field <= o_field + 8'h01;
        // Fixed 12 cycle task, so a run never spans a field
        run_q <= i_active ? run_q + 4'h1 : 4'h0;
        o_done <= run_q == 4'hb;
    end
endmodule

//--- verification/scaler_task_handler_test.sv
// Testbench for the scaler task handler driven by a field source model.
// Assumes handler, checker and model sources are compiled first.
`timescale 1ns/10ps
module scaler_task_handler_test;
    reg clk, srst, soft_n, en_a, en_b, vedge;
    reg [7:0] cfg_a, cfg_b, f0;
    wire vp, hr, field_identifier, offs, done, act, bsel, tog, d6, d7, flag, fido, idle;
    wire [7:0] field;
    integer bad_count, tests_run, n;
    sth_src_model u_src (.i_clk_sys(clk), .i_srst(srst), .i_active(act),
        .o_vpulse(vp), .o_decoder_line_reference(hr), .o_fid(field_identifier), .o_offs(offs),
        .o_done(done), .o_field(field));
    sth_task_handler u_dut (.i_clk_sys(clk), .i_srst(srst),
        .i_scaler_soft_reset_n(soft_n), .i_task_a_enable(en_a),
        .i_task_b_enable(en_b), .i_cfg_a(cfg_a), .i_cfg_b(cfg_b),
        .i_ext_source(1'b0), .i_sys_60hz(1'b0), .i_vtrig_sel_hi(1'b0),
        .i_vtrig_edge_sel(vedge), .i_htrig_edge_sel(1'b0),
        .i_decoder_vertical_pulse(vp), .i_decoder_line_reference(hr),
        .i_ext_vsync(vp), .i_ext_sav(hr), .i_field_identifier(field_identifier),
        .i_offsets_reached(offs), .i_task_done(done), .o_task_active(act),
        .o_task_b_sel(bsel), .o_toggle(tog), .o_sav_d6(d6), .o_sav_d7(d7),
        .o_task_flag(flag), .o_field_id_out(fido), .o_idle(idle));
    task chk(input logic seen, input logic exp);
        tests_run = tests_run + 1;
        if (seen !== exp) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED %0t: saw %b want %b", $time, seen, exp);
        end
    endtask
    task print_verdict;
        $display("tests_run %0d bad_count %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task step;
        @(posedge clk);
        #2;
    endtask
    task wait_act(input logic v);
        n = 0;
        while (act !== v && n < 3000) begin
            step;
            n = n + 1;
        end
        if (n == 3000) begin
            bad_count = bad_count + 1;
            $display("CHECK FAILED %0t: wait timed out", $time);
            print_verdict;
        end
    endtask
    task t_alt;
        chk(idle, 1'b1);
        chk(d7, 1'b1);
        cfg_a = 8'h80;
        cfg_b = 8'h04;
        en_a = 1'b1;
        en_b = 1'b1;
        wait_act(1'b1);
        chk(bsel, 1'b1);
        chk(tog, 1'b1);
        repeat (2) step;
        chk(d7, 1'b1);
        wait_act(1'b0);
        wait_act(1'b1);
        chk(bsel, 1'b1);
        chk(tog, 1'b0);
        wait_act(1'b0);
        wait_act(1'b1);
        chk(bsel, 1'b0);
        en_a = 1'b0;
        en_b = 1'b0;
        repeat (2) step;
        chk(d7, 1'b0);
        chk(flag, 1'b1);
        chk(act, 1'b1);
        wait_act(1'b0);
        repeat (300) step;
        chk(idle, 1'b1);
        $display("alternation test done");
    endtask
    task t_fid;
        vedge = 1'b1;
        cfg_a = 8'h03;
        en_a = 1'b1;
        repeat (2) begin
            wait_act(1'b1);
            chk(field_identifier, 1'b1);
            chk(bsel, 1'b0);
            repeat (2) step;
            chk(d6, field_identifier);
            wait_act(1'b0);
        end
        $display("field id test done");
    endtask
    task t_soft;
        wait_act(1'b1);
        cfg_a = 8'h40;
        soft_n = 1'b0;
        en_a = 1'b0;
        repeat (5) step;
        chk(act, 1'b0);
        chk(bsel, 1'b1);
        chk(tog, 1'b0);
        soft_n = 1'b1;
        vedge = 1'b0;
        $display("soft reset test done");
    endtask
    task t_skip;
        cfg_b = 8'h51;
        en_b = 1'b1;
        wait_act(1'b1);
        f0 = field;
        wait_act(1'b0);
        wait_act(1'b1);
        chk(field - f0 == 8'h03, 1'b1);
        repeat (2) step;
        chk(d6, tog);
        chk(fido, tog);
        $display("field skip test done");
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        bad_count = 0;
        tests_run = 0;
        srst = 1'b1;
        soft_n = 1'b1;
        en_a = 1'b0;
        en_b = 1'b0;
        vedge = 1'b0;
        cfg_a = 8'h00;
        cfg_b = 8'h00;
        repeat (5) @(posedge clk);
        #2;
        srst = 1'b0;
        t_alt;
        t_fid;
        t_soft;
        t_skip;
        print_verdict;
    end
endmodule
bind sth_task_handler sth_task_handler_chk u_chk (.i_clk_sys(i_clk_sys),
    .i_srst(i_srst), .i_scaler_soft_reset_n(i_scaler_soft_reset_n),
    .i_task_done(i_task_done), .o_task_active(o_task_active),
    .o_task_b_sel(o_task_b_sel), .o_toggle(o_toggle), .o_sav_d6(o_sav_d6),
    .o_sav_d7(o_sav_d7), .o_task_flag(o_task_flag),
    .o_field_id_out(o_field_id_out), .o_idle(o_idle));
